// ===== core/iop_top.sv
// General purpose I/O ports with AXI4-Lite registers and bus pin sharing.
// Assumes pins and mode inputs are synchronous to CORE_CLK.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module iop_top (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic [iop_pkg::IOP_AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [iop_pkg::IOP_AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [2:0] MODE_SEL,
    input wire logic [iop_pkg::IOP_NPORT-1:0][iop_pkg::IOP_W-1:0] PIN_IN,
    output iop_pkg::iop_pad_t [iop_pkg::IOP_NPORT-1:0] PIN_PAD,
    output logic [iop_pkg::IOP_NPORT-1:0][iop_pkg::IOP_W-1:0] PULLUP_EN,
    input wire logic [23:0] BUS_ADDR,
    input wire logic [iop_pkg::IOP_W-1:0] BUS_DATA_HI_OUT,
    input wire logic BUS_DATA_HI_OE,
    output logic [iop_pkg::IOP_W-1:0] BUS_DATA_HI_IN,
    input wire logic CHIP_SELECT_FIVE,
    input wire logic CHIP_SELECT_FOUR,
    output logic MANUAL_RESET_IN
);
    import iop_pkg::*;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    // Map a byte address to a port register that really exists
    function automatic iop_dec_t iop_decode(input logic [IOP_AW-1:0] a);
        iop_dec_t d;
        d.port = a[IOP_ADDR_PORT_LSB +: 4];
        d.sel = a[IOP_ADDR_SEL_LSB +: 3];
        d.ok = 1'b0;
        if (int'(d.port) < IOP_NPORT) begin
            unique case (d.sel)
                IOP_SEL_DIR, IOP_SEL_DATA: d.ok = IOP_HAS_DIR[d.port];
                IOP_SEL_PIN: d.ok = 1'b1;
                IOP_SEL_PU: d.ok = IOP_HAS_PU[d.port];
                IOP_SEL_OD: d.ok = IOP_HAS_OD[d.port];
                default: d.ok = 1'b0;
            endcase
        end
        return d;
    endfunction : iop_decode

    // ****************************************************************
    // State
    // ****************************************************************
    logic [IOP_NPORT-1:0][IOP_W-1:0] dir_ff;   // Direction registers
    logic [IOP_NPORT-1:0][IOP_W-1:0] data_ff;  // Output data registers
    logic [IOP_NPORT-1:0][IOP_W-1:0] pu_ff;    // Pull-up control registers
    logic [IOP_NPORT-1:0][IOP_W-1:0] od_ff;    // Open-drain control registers
    logic [2:0] mode_ff;                       // Operating mode
    logic aw_got_ff;                           // Write address held
    logic w_got_ff;                            // Write data held
    logic [IOP_AW-1:0] awaddr_ff;              // Held write address
    logic [IOP_W-1:0] wbyte_ff;                // Held write byte
    logic wlane_ff;                            // Byte lane 0 enabled
    logic wr_go;                               // Write performed this cycle
    iop_dec_t wdec;                            // Decoded write target
    iop_dec_t rdec;                            // Decoded read target
    logic expanded;                            // Modes 4 to 6
    logic mode45;                              // Modes 4 or 5
    iop_fn_t [IOP_NPORT-1:0] fn;               // Bus function per port

    // ****************************************************************
    // Mode
    // ****************************************************************
    // Mode pins are sampled every cycle
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_ff <= IOP_MODE_7;
        end else begin
            mode_ff <= MODE_SEL;
        end
    end

    always_comb begin
        mode45 = (mode_ff == IOP_MODE_4) || (mode_ff == IOP_MODE_5);
        expanded = mode45 || (mode_ff == IOP_MODE_6);
    end

    // ****************************************************************
    // AXI write channel
    // ****************************************************************
    assign S_AXI_AWREADY = !aw_got_ff && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_got_ff && !S_AXI_BVALID;
    assign wr_go = aw_got_ff && w_got_ff && !S_AXI_BVALID;
    assign wdec = iop_decode(awaddr_ff);

    // Address and data are taken in either order, answered after both
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wbyte_ff <= IOP_RST_BYTE;
            wlane_ff <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= IOP_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_ff <= 1'b1;
                wbyte_ff <= S_AXI_WDATA[IOP_W-1:0];
                wlane_ff <= S_AXI_WSTRB[0];
            end
            if (wr_go) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                // Pin state is read only, so a write to it is refused
                S_AXI_BRESP <= (wdec.ok && wdec.sel != IOP_SEL_PIN) ?
                    IOP_RESP_OKAY : IOP_RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Port registers
    // ****************************************************************
    for (genvar p = 0; p < IOP_NPORT; p++) begin : g_port
        logic hit;                             // Write aimed at this port
        assign hit = wr_go && wlane_ff && wdec.ok && (int'(wdec.port) == p);

        // Direction and data only where the port has them
        always_ff @(posedge CORE_CLK or negedge RST_B) begin
            if (!RST_B) begin
                dir_ff[p] <= IOP_RST_BYTE;
                data_ff[p] <= IOP_RST_BYTE;
                pu_ff[p] <= IOP_RST_BYTE;
                od_ff[p] <= IOP_RST_BYTE;
            end else if (hit) begin
                if (wdec.sel == IOP_SEL_DIR) begin
                    dir_ff[p] <= wbyte_ff;
                end
                if (wdec.sel == IOP_SEL_DATA) begin
                    data_ff[p] <= wbyte_ff;
                end
                if (wdec.sel == IOP_SEL_PU) begin
                    pu_ff[p] <= wbyte_ff;
                end
                if (wdec.sel == IOP_SEL_OD) begin
                    od_ff[p] <= wbyte_ff;
                end
            end
        end

        // Pull-up acts only on pins whose direction bit is clear
        always_ff @(posedge CORE_CLK or negedge RST_B) begin
            if (!RST_B) begin
                PULLUP_EN[p] <= IOP_RST_BYTE;
            end else begin
                PULLUP_EN[p] <= pu_ff[p] & ~dir_ff[p];
            end
        end

        // Output stage of the port
        iop_pin_cell u_cell (
            .clk(CORE_CLK),
            .rst_b(RST_B),
            .dir(dir_ff[p]),
            .data(data_ff[p]),
            .od(od_ff[p]),
            .fn(fn[p]),
            .pad(PIN_PAD[p])
        );
    end

    // ****************************************************************
    // Bus functions sharing the pins
    // ****************************************************************
    always_comb begin
        fn = '0;
        // Input-only ports never drive
        fn[IOP_P4].en = '1;
        fn[IOP_P9].en = '1;
        // Manual reset pin is an input in every mode
        fn[IOP_P7].en[IOP_P7_MANUAL_RESET_BIT] = 1'b1;
        if (expanded) begin
            fn[IOP_P7].en[IOP_P7_CHIP_SELECT_FIVE_BIT] = 1'b1;
            fn[IOP_P7].val[IOP_P7_CHIP_SELECT_FIVE_BIT] = CHIP_SELECT_FIVE;
            fn[IOP_P7].drive[IOP_P7_CHIP_SELECT_FIVE_BIT] = 1'b1;
            fn[IOP_P7].en[IOP_P7_CHIP_SELECT_FOUR_BIT] = 1'b1;
            fn[IOP_P7].val[IOP_P7_CHIP_SELECT_FOUR_BIT] = CHIP_SELECT_FOUR;
            fn[IOP_P7].drive[IOP_P7_CHIP_SELECT_FOUR_BIT] = 1'b1;
            fn[IOP_PA].en[3:0] = '1;
            fn[IOP_PA].val[3:0] = BUS_ADDR[IOP_PA_ADDR_LSB +: 4];
            fn[IOP_PA].drive[3:0] = '1;
            fn[IOP_PB].en = '1;
            fn[IOP_PB].val = BUS_ADDR[IOP_PB_ADDR_LSB +: IOP_W];
            fn[IOP_PB].drive = '1;
            fn[IOP_PD].en = '1;
            fn[IOP_PD].val = BUS_DATA_HI_OUT;
            fn[IOP_PD].drive = {IOP_W{BUS_DATA_HI_OE}};
        end
        if (mode45) begin
            fn[IOP_PC].en = '1;
        end else if (mode_ff == IOP_MODE_6) begin
            fn[IOP_PC].en = dir_ff[IOP_PC];
        end
        fn[IOP_PC].val = BUS_ADDR[IOP_PC_ADDR_LSB +: IOP_W];
        fn[IOP_PC].drive = '1;
    end

    // Data bus and manual reset inputs are registered straight from pins
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            BUS_DATA_HI_IN <= IOP_RST_BYTE;
            MANUAL_RESET_IN <= 1'b1;
        end else begin
            BUS_DATA_HI_IN <= PIN_IN[IOP_PD];
            MANUAL_RESET_IN <=
                PIN_IN[IOP_P7][IOP_P7_MANUAL_RESET_BIT];
        end
    end

    // ****************************************************************
    // AXI read channel
    // ****************************************************************
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign rdec = iop_decode(S_AXI_ARADDR);

    // One read in flight; data captured when the address is taken
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= IOP_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= rdec.ok ? IOP_RESP_OKAY : IOP_RESP_SLVERR;
            if (rdec.ok) begin
                unique case (rdec.sel)
                    IOP_SEL_DIR: S_AXI_RDATA[IOP_W-1:0] <= dir_ff[rdec.port];
                    IOP_SEL_DATA: S_AXI_RDATA[IOP_W-1:0] <= data_ff[rdec.port];
                    IOP_SEL_PIN:
                        S_AXI_RDATA[IOP_W-1:0] <= PIN_IN[rdec.port];
                    IOP_SEL_PU: S_AXI_RDATA[IOP_W-1:0] <= pu_ff[rdec.port];
                    IOP_SEL_OD: S_AXI_RDATA[IOP_W-1:0] <= od_ff[rdec.port];
                    default: S_AXI_RDATA <= '0;
                endcase
            end
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_dir_write;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (wr_go && wlane_ff && wdec.ok && wdec.sel == IOP_SEL_DIR)
        |=> dir_ff[$past(wdec.port)] == $past(wbyte_ff);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("Direction write not stored");

    property p_data_readback;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (S_AXI_ARVALID && S_AXI_ARREADY && rdec.ok
         && rdec.sel == IOP_SEL_DATA)
        |=> S_AXI_RVALID
            && S_AXI_RDATA[IOP_W-1:0] == $past(data_ff[rdec.port]);
    endproperty
    a_data_readback: assert property (p_data_readback)
        else $error("Output data read back wrong");

    property p_pin_read;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (S_AXI_ARVALID && S_AXI_ARREADY && rdec.ok && rdec.sel == IOP_SEL_PIN)
        |=> S_AXI_RDATA[IOP_W-1:0] == $past(PIN_IN[rdec.port]);
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("Pin state read not the pin level");

    property p_input_only_err;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (S_AXI_ARVALID && S_AXI_ARREADY && int'(rdec.port) == IOP_P4
         && rdec.sel == IOP_SEL_DIR) |=> S_AXI_RRESP == IOP_RESP_SLVERR;
    endproperty
    a_input_only_err: assert property (p_input_only_err)
        else $error("Input-only port answered a direction read");

    property p_pullup;
        @(posedge CORE_CLK) disable iff (!RST_B)
        ##1 PULLUP_EN == ($past(pu_ff) & ~$past(dir_ff));
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("Pull-up enable wrong");

    property p_open_drain;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (mode_ff == IOP_MODE_7 && od_ff[IOP_P3][0] && dir_ff[IOP_P3][0]
         && data_ff[IOP_P3][0]) |=> PIN_PAD[IOP_P3].oe_b[0];
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("Open-drain pin drove high");

    property p_mode6_addr;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (mode_ff == IOP_MODE_6 && dir_ff[IOP_PC][0])
        |=> !PIN_PAD[IOP_PC].oe_b[0]
            && PIN_PAD[IOP_PC].drv[0] == $past(BUS_ADDR[0]);
    endproperty
    a_mode6_addr: assert property (p_mode6_addr)
        else $error("Port C did not carry address in mode 6");

    property p_mode4_addr;
        @(posedge CORE_CLK) disable iff (!RST_B)
        mode45 |=> PIN_PAD[IOP_PC].oe_b == '0;
    endproperty
    a_mode4_addr: assert property (p_mode4_addr)
        else $error("Port C not driving address in modes 4 and 5");

    property p_porta_addr;
        @(posedge CORE_CLK) disable iff (!RST_B)
        expanded |=> PIN_PAD[IOP_PA].drv[3:0] == $past(BUS_ADDR[19:16]);
    endproperty
    a_porta_addr: assert property (p_porta_addr)
        else $error("Port A low nibble lost the address");

    property p_input_port;
        @(posedge CORE_CLK) disable iff (!RST_B)
        ##1 PIN_PAD[IOP_P9].oe_b == '1;
    endproperty
    a_input_port: assert property (p_input_port)
        else $error("Input-only port drove a pin");

endmodule : iop_top
`default_nettype wire

// ===== core/iop_pkg.sv
// Shared constants and carrier types for the general purpose I/O port block.
// Assumes one 125 MHz core clock and an AXI4-Lite register slave.
package iop_pkg;

    // ****************************************************************
    // Port set and widths
    // ****************************************************************
    localparam int IOP_NPORT = 10;             // Ports in the block
    localparam int IOP_W = 8;                  // Pins per port
    localparam int IOP_P1 = 0;                 // Port 1
    localparam int IOP_P3 = 1;                 // Port 3
    localparam int IOP_P4 = 2;                 // Port 4, input only
    localparam int IOP_P7 = 3;                 // Port 7
    localparam int IOP_P9 = 4;                 // Port 9, input only
    localparam int IOP_PA = 5;                 // Port A
    localparam int IOP_PB = 6;                 // Port B
    localparam int IOP_PC = 7;                 // Port C
    localparam int IOP_PD = 8;                 // Port D
    localparam int IOP_PE = 9;                 // Port E

    // Feature masks, one bit per port index
    localparam logic [IOP_NPORT-1:0] IOP_HAS_DIR = 10'h3EB;
    localparam logic [IOP_NPORT-1:0] IOP_HAS_PU = 10'h3E0;
    localparam logic [IOP_NPORT-1:0] IOP_HAS_OD = 10'h022;

    // Special pins of port 7
    localparam int IOP_P7_MANUAL_RESET_BIT = 4;     // Manual reset input pin
    localparam int IOP_P7_CHIP_SELECT_FIVE_BIT = 1; // Chip select five pin
    localparam int IOP_P7_CHIP_SELECT_FOUR_BIT = 0; // Chip select four pin

    // Address slices carried on ports in expanded modes
    localparam int IOP_PA_ADDR_LSB = 16;       // Port A low nibble base
    localparam int IOP_PB_ADDR_LSB = 8;        // Port B base
    localparam int IOP_PC_ADDR_LSB = 0;        // Port C base

    // ****************************************************************
    // Register map: byte address = port * stride + select * 4
    // ****************************************************************
    localparam int IOP_AW = 12;                // AXI address width
    localparam int IOP_ADDR_PORT_LSB = 5;      // Port index field
    localparam int IOP_ADDR_SEL_LSB = 2;       // Register select field
    localparam logic [2:0] IOP_SEL_DIR = 3'h0; // Direction register
    localparam logic [2:0] IOP_SEL_DATA = 3'h1;// Output data register
    localparam logic [2:0] IOP_SEL_PIN = 3'h2; // Pin state, read only
    localparam logic [2:0] IOP_SEL_PU = 3'h3;  // Pull-up control register
    localparam logic [2:0] IOP_SEL_OD = 3'h4;  // Open-drain control register
    localparam logic [IOP_W-1:0] IOP_RST_BYTE = 8'h00;

    // AXI responses
    localparam logic [1:0] IOP_RESP_OKAY = 2'h0;
    localparam logic [1:0] IOP_RESP_SLVERR = 2'h2;

    // Operating mode codes
    localparam logic [2:0] IOP_MODE_4 = 3'h4;
    localparam logic [2:0] IOP_MODE_5 = 3'h5;
    localparam logic [2:0] IOP_MODE_6 = 3'h6;
    localparam logic [2:0] IOP_MODE_7 = 3'h7;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic [IOP_W-1:0] drv;                 // Level offered to the pad
        logic [IOP_W-1:0] oe_b;                // Low while the pad is driven
    } iop_pad_t;

    typedef struct packed {
        logic [IOP_W-1:0] en;                  // Bus function owns the pin
        logic [IOP_W-1:0] val;                 // Bus function level
        logic [IOP_W-1:0] drive;               // Bus function drives the pin
    } iop_fn_t;

    typedef struct packed {
        logic ok;                              // Register exists
        logic [3:0] port;                      // Port index
        logic [2:0] sel;                       // Register select
    } iop_dec_t;

endpackage : iop_pkg

// ===== core/iop_pin_cell.sv
// One port's output stage: bus override, direction and open-drain logic.
// Assumes the pad resolves its wire from the registered level and enable.
`timescale 1ns/1ps
`default_nettype none
module iop_pin_cell (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [iop_pkg::IOP_W-1:0] dir,
    input wire logic [iop_pkg::IOP_W-1:0] data,
    input wire logic [iop_pkg::IOP_W-1:0] od,
    input wire iop_pkg::iop_fn_t fn,
    output var iop_pkg::iop_pad_t pad
);
    import iop_pkg::*;

    // ****************************************************************
    // Pin selection
    // ****************************************************************
    logic [IOP_W-1:0] val;                     // Level chosen per pin
    logic [IOP_W-1:0] drive;                   // Drive request per pin

    // Bus function wins over the general port setting
    always_comb begin
        val = (fn.en & fn.val) | (~fn.en & data);
        drive = (fn.en & fn.drive) | (~fn.en & dir);
    end

    // ****************************************************************
    // Registered pad outputs
    // ****************************************************************
    // Open drain drops the high-side drive so a one floats
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pad.drv <= IOP_RST_BYTE;
            pad.oe_b <= ~IOP_RST_BYTE;
        end else begin
            pad.drv <= val;
            pad.oe_b <= ~(drive & ~(od & val));
        end
    end

endmodule : iop_pin_cell
`default_nettype wire

// ===== tb/iop_pin_model.sv
// Board-side pin model: resolves each pin from pad, pull-up and bench drive.
// Assumes the bench forces a pin only through ext and ext_oe.
`timescale 1ns/1ps
`default_nettype none
module iop_pin_model (
    input wire iop_pkg::iop_pad_t [iop_pkg::IOP_NPORT-1:0] pad,
    input wire logic [iop_pkg::IOP_NPORT-1:0][iop_pkg::IOP_W-1:0] pu,
    input wire logic [iop_pkg::IOP_NPORT-1:0][iop_pkg::IOP_W-1:0] ext,
    input wire logic [iop_pkg::IOP_NPORT-1:0][iop_pkg::IOP_W-1:0] ext_oe,
    output logic [iop_pkg::IOP_NPORT-1:0][iop_pkg::IOP_W-1:0] pin
);
    import iop_pkg::*;
    // Pad wins, then board drive, then pull-up; a floating pin shows junk
    always_comb begin
        for (int p = 0; p < IOP_NPORT; p++) begin
            for (int b = 0; b < IOP_W; b++) begin
                if (!pad[p].oe_b[b]) pin[p][b] = pad[p].drv[b];
                else if (ext_oe[p][b]) pin[p][b] = ext[p][b];
                else if (pu[p][b]) pin[p][b] = 1'b1;
                else pin[p][b] = ~ext[p][b];
            end
        end
    end
endmodule : iop_pin_model
`default_nettype wire

// ===== tb/io_port_pin_control_test.sv
// Register-level test of the I/O port block over AXI4-Lite.
// Assumes pins are resolved by the board-side pin model.
`timescale 1ns/1ps
`default_nettype none
module io_port_pin_control_test;
    import iop_pkg::*;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, d;
    logic awr, wrr, bv, arr, rv, mri, dhoe = 1, cs_five = 0, cs_four = 1;
    logic [1:0] br, rr, r;
    logic [2:0] mode = 3'h7;
    logic [23:0] badr = 24'h9B5C3E;
    logic [7:0] dho = 8'hA7, dhi;
    logic [9:0][7:0] pin, pue, ext = '0, exo = '0;
    iop_pad_t [9:0] pad;
    int miscompares = 0, checks_done = 0;
    always #4 clk = ~clk;
    iop_top iop_top_i (.CORE_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr),
        .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rry), .MODE_SEL(mode), .PIN_IN(pin), .PIN_PAD(pad),
        .PULLUP_EN(pue), .BUS_ADDR(badr), .BUS_DATA_HI_OUT(dho),
        .BUS_DATA_HI_OE(dhoe), .BUS_DATA_HI_IN(dhi),
        .CHIP_SELECT_FIVE(cs_five), .CHIP_SELECT_FOUR(cs_four),
        .MANUAL_RESET_IN(mri));
    iop_pin_model iop_pin_model_i (.pad(pad), .pu(pue), .ext(ext),
        .ext_oe(exo), .pin(pin));
    // Report the counts and stop
    task automatic give_verdict();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Cut a hung handshake short
    task automatic tmo(input int n);
        if (n > 40) begin
            miscompares++;
            give_verdict();
        end
    endtask : tmo
    function automatic logic [11:0] ad(input int p, input int s);
        return 12'(p * 32 + s * 4);
    endfunction : ad
    // Write: address and data offered together, each dropped when taken
    task automatic wr(input int p, input int s, input logic [7:0] v);
        int n;
        logic a, w;
        a = 0; w = 0; n = 0;
        awa <= ad(p, s); wd <= {24'h0, v}; awv <= 1; wv <= 1; bry <= 1;
        while (!(a && w)) begin
            @(posedge clk); n++; tmo(n);
            if (!a && awr) begin a = 1; awv <= 0; end
            if (!w && wrr) begin w = 1; wv <= 0; end
        end
        while (!bv) begin @(posedge clk); n++; tmo(n); end
        r = br; bry <= 0; @(posedge clk);
    endtask : wr
    task automatic rd(input int p, input int s);
        int n;
        n = 0; ara <= ad(p, s); arv <= 1; rry <= 1;
        do begin @(posedge clk); n++; tmo(n); end while (!arr);
        arv <= 0;
        while (!rv) begin @(posedge clk); n++; tmo(n); end
        d = rdat; r = rr; rry <= 0; @(posedge clk);
    endtask : rd
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask : settle
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1; @(posedge clk);
        rd(IOP_PC, 0); chk(d, 32'h0);
        chk(pad[IOP_PC].oe_b, 8'hFF);
        wr(IOP_PB, 0, 8'hFF); wr(IOP_PB, 1, 8'hA5);
        chk(r, IOP_RESP_OKAY);
        settle(); chk(pad[IOP_PB], 16'hA500);
        wr(IOP_PB, 0, 8'h00); ext[IOP_PB] <= 8'h6A; exo[IOP_PB] <= 8'hFF;
        settle(); chk(pad[IOP_PB].oe_b, 8'hFF);
        rd(IOP_PB, 2); chk(d, 32'h6A);
        rd(IOP_PB, 1); chk(d, 32'hA5);
        wr(IOP_P4, 0, 8'hFF); chk(r, IOP_RESP_SLVERR);
        rd(IOP_P9, 1); chk(r, IOP_RESP_SLVERR);
        rd(IOP_P4, 0); chk(r, IOP_RESP_SLVERR);
        chk(d, 32'h0);
        ext[IOP_P4] <= 8'h3C; exo[IOP_P4] <= 8'hFF;
        rd(IOP_P4, 2); chk(d, 32'h3C);
        wr(IOP_PB, 0, 8'h0F); wr(IOP_PB, 3, 8'hFF); exo[IOP_PB] <= 8'h00;
        settle(); chk(pue[IOP_PB], 8'hF0);
        wr(IOP_P3, 0, 8'hFF); wr(IOP_P3, 1, 8'h0F); wr(IOP_P3, 4, 8'hFF);
        settle(); chk(pad[IOP_P3].oe_b, 8'h0F);
        exo[IOP_P7] <= 8'h10; settle(); chk(mri, 1'b0);
        wr(IOP_PC, 0, 8'h0F); mode <= IOP_MODE_6; settle();
        chk(pad[IOP_PC].oe_b, 8'hF0);
        chk(pad[IOP_PC].drv[3:0], badr[3:0]);
        for (int m = 4; m < 6; m++) begin
            mode <= 3'(m); settle();
            chk(pad[IOP_PC], {badr[7:0], 8'h00});
            chk(pad[IOP_PD], {dho, 8'h00});
            chk(dhi, dho);
            chk({pad[IOP_PA].drv[3:0], pad[IOP_PA].oe_b[3:0]},
                {badr[19:16], 4'h0});
            chk(pad[IOP_P7].drv[1:0], {cs_five, cs_four});
        end
        mode <= IOP_MODE_7; settle();
        chk(pad[IOP_PC].drv[3:0], 4'h0);
        chk(pad[IOP_PD].oe_b, 8'hFF);
        chk(pad[IOP_PA].oe_b[3:0], 4'hF);
        chk(pad[IOP_P7].oe_b[1:0], 2'h3);
        give_verdict();
    end
endmodule : io_port_pin_control_test
`default_nettype wire
